/* File: rtl/unvm_top.sv */
// User nonvolatile byte store: core read port plus programming port.
// Assumes core logic and programming port share clk_i; no bus registers.
//
// Contract
// - The store is eight independent banks of 128 bits each.
// - The 1 kbit contents persist, untouched by reset.
// - The core reads one byte per access over a synchronous port.
// - The upper three address bits select one of the eight banks.
// - The lower four address bits select one of 16 bytes in that bank.
// - The core read port has no way to write or erase the store.
// - Contents can be read both from the programming port and the core.
// - Programming is a bank erase then byte writes, apart from core config.
// - Loaded data may be decrypted on chip, chosen on each load.
`timescale 1ns/1ps
`default_nettype none

`include "unvm_map.svh"

module unvm_top #(
  parameter logic [127:0] KEY = `UNVM_KEY_DEFAULT // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Core read port
  input wire logic core_rd_en_i,
  input wire unvm_pkg::unvm_addr_t core_addr_i,
  output logic [`UNVM_DATA_W-1:0] core_data_o,
  output logic core_valid_o,
  // Programming port
  input wire logic prog_req_i,
  input wire unvm_pkg::unvm_op_t prog_op_i,
  input wire unvm_pkg::unvm_addr_t prog_addr_i,
  input wire unvm_pkg::unvm_byte_t prog_data_i,
  input wire logic prog_decrypt_i,
  output logic prog_busy_o,
  output logic prog_ack_o,
  output logic prog_err_o,
  output logic [`UNVM_DATA_W-1:0] prog_rdata_o
);
  import unvm_pkg::*;

  // Bank field of an address
  function automatic unvm_bank_t bank_of(input unvm_addr_t a);
    bank_of = a[`UNVM_BANK_MSB:`UNVM_BANK_LSB];
  endfunction

  // Byte field of an address
  function automatic unvm_idx_t byte_of(input unvm_addr_t a);
    byte_of = a[`UNVM_BYTE_MSB:`UNVM_BYTE_LSB];
  endfunction

  // Key byte picked by byte index
  function automatic unvm_byte_t key_byte(input unvm_idx_t i);
    key_byte = KEY[{i, 3'h0} +: `UNVM_DATA_W];
  endfunction

  unvm_mem_if mif ();

  unvm_state_t state_ff;
  unvm_state_t nxt_state;
  unvm_bank_t bank_ff;
  unvm_bank_t nxt_bank;
  unvm_idx_t idx_ff;
  unvm_idx_t nxt_idx;
  unvm_byte_t wdata_ff;
  unvm_byte_t nxt_wdata;
  logic busy_ff;
  logic ack_ff;
  logic nxt_ack;
  logic err_ff;
  logic nxt_err;
  logic core_valid_ff;

  // Request decode
  // Busy requests are flagged, never queued
  wire logic req_idle = prog_req_i && (state_ff == UNVM_ST_IDLE);
  wire logic req_refused = prog_req_i && (state_ff != UNVM_ST_IDLE);
  wire logic req_bad = req_idle && (prog_op_i == UNVM_OP_NONE);
  wire unvm_bank_t req_bank = bank_of(prog_addr_i);
  wire unvm_idx_t req_idx = byte_of(prog_addr_i);

  // Optional decryption of loaded byte
  wire unvm_byte_t load_byte = prog_decrypt_i ?
                               (prog_data_i ^ key_byte(req_idx)) : prog_data_i;

  // Store address of the current sequencer step
  wire unvm_addr_t seq_addr = {bank_ff, idx_ff};
  wire logic erase_last = (idx_ff == unvm_idx_t'(`UNVM_ERASE_CYC - 1));

  // Flash-style program only clears bits left set by erase
  // Without an erase first, a write can only clear bits
  wire unvm_byte_t merged = mif.rb_data & wdata_ff;

  // Core read port: read-only access, address taken straight from core_addr_i
  // No write enable reaches the array from this side
  assign mif.ra_en = core_rd_en_i;
  assign mif.ra_addr = {bank_of(core_addr_i), byte_of(core_addr_i)};

  // Programming port array access
  assign mif.rb_en = (state_ff == UNVM_ST_WRRD) || (state_ff == UNVM_ST_RDWT);
  assign mif.rb_addr = seq_addr;
  assign mif.wr_en = (state_ff == UNVM_ST_ERASE) || (state_ff == UNVM_ST_WRPUT);
  assign mif.wr_addr = seq_addr;
  assign mif.wr_data = (state_ff == UNVM_ST_ERASE) ? `UNVM_ERASED_BYTE : merged;

  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    nxt_bank = bank_ff;
    nxt_idx = idx_ff;
    nxt_wdata = wdata_ff;
    nxt_ack = 1'b0;
    nxt_err = req_refused || req_bad;
    case (state_ff)
      UNVM_ST_IDLE: begin
        if (req_idle) begin
          nxt_bank = req_bank;
          nxt_idx = req_idx;
          nxt_wdata = load_byte;
          case (prog_op_i)
            UNVM_OP_ERASE: begin
              nxt_state = UNVM_ST_ERASE;
              nxt_idx = '0;
            end
            UNVM_OP_WRITE: begin
              nxt_state = UNVM_ST_WRRD;
            end
            UNVM_OP_READ: begin
              nxt_state = UNVM_ST_RDWT;
            end
            default: begin
              nxt_state = UNVM_ST_IDLE;
            end
          endcase
        end
      end
      UNVM_ST_ERASE: begin
        nxt_idx = idx_ff + unvm_idx_t'(1);
        if (erase_last) begin
          nxt_state = UNVM_ST_IDLE;
          nxt_ack = 1'b1;
        end
      end
      UNVM_ST_WRRD: begin
        nxt_state = UNVM_ST_WRPUT;
      end
      UNVM_ST_WRPUT: begin
        nxt_state = UNVM_ST_IDLE;
        nxt_ack = 1'b1;
      end
      UNVM_ST_RDWT: begin
        nxt_state = UNVM_ST_IDLE;
        nxt_ack = 1'b1;
      end
      default: begin
        nxt_state = UNVM_ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  // Array contents stay outside this reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= UNVM_ST_IDLE;
      bank_ff <= '0;
      idx_ff <= '0;
      wdata_ff <= `UNVM_ZERO_BYTE;
    end else begin
      state_ff <= nxt_state;
      bank_ff <= nxt_bank;
      idx_ff <= nxt_idx;
      wdata_ff <= nxt_wdata;
    end
  end

  // Programming port status flags
  // Busy follows next state, so it falls with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != UNVM_ST_IDLE);
      ack_ff <= nxt_ack;
      err_ff <= nxt_err;
    end
  end

  // Core read strobe follows the registered byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_valid_ff <= 1'b0;
    end else begin
      core_valid_ff <= core_rd_en_i;
    end
  end

  // Byte array, contents kept across reset
  // Second read port lets core reads run during programming
  unvm_mem #(
    .DEPTH(`UNVM_BANKS * `UNVM_BANK_BYTES)
  ) u_mem (
    .clk_i(clk_i),
    .port(mif.mem)
  );

  // Outputs
  // Data from array read flops, flags from local flops
  assign core_data_o = mif.ra_data;
  assign core_valid_o = core_valid_ff;
  assign prog_rdata_o = mif.rb_data;
  assign prog_busy_o = busy_ff;
  assign prog_ack_o = ack_ff;
  assign prog_err_o = err_ff;
endmodule

`default_nettype wire

/* File: rtl/unvm_map.svh */
// Constants for the user nonvolatile byte store: geometry, fields, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef UNVM_MAP_SVH
`define UNVM_MAP_SVH

// Geometry
`define UNVM_BANKS 8
`define UNVM_BANK_BYTES 16
`define UNVM_DATA_W 8
`define UNVM_ADDR_W 7
`define UNVM_BITS_TOTAL 1024

// Address fields
`define UNVM_BANK_MSB 6
`define UNVM_BANK_LSB 4
`define UNVM_BYTE_MSB 3
`define UNVM_BYTE_LSB 0
`define UNVM_BANK_W 3
`define UNVM_BYTE_W 4

// Values
`define UNVM_ERASED_BYTE 8'hFF
`define UNVM_ZERO_BYTE 8'h00
`define UNVM_KEY_DEFAULT 128'h0123456789ABCDEF0F1E2D3C4B5A6978

// Timing: erase clears one byte per cycle across a bank
`define UNVM_ERASE_CYC `UNVM_BANK_BYTES

`endif

/* File: rtl/unvm_pkg.sv */
// Types shared by the user nonvolatile byte store modules.
// Assumes unvm_map.svh is on the include path.
`include "unvm_map.svh"

package unvm_pkg;
  typedef logic [`UNVM_ADDR_W-1:0] unvm_addr_t;
  typedef logic [`UNVM_DATA_W-1:0] unvm_byte_t;
  typedef logic [`UNVM_BANK_W-1:0] unvm_bank_t;
  typedef logic [`UNVM_BYTE_W-1:0] unvm_idx_t;

  // Programming port operations
  typedef enum logic [1:0] {
    UNVM_OP_ERASE = 2'b00,
    UNVM_OP_WRITE = 2'b01,
    UNVM_OP_READ  = 2'b10,
    UNVM_OP_NONE  = 2'b11
  } unvm_op_t;

  // Programming sequencer states
  typedef enum logic [2:0] {
    UNVM_ST_IDLE  = 3'b000,
    UNVM_ST_ERASE = 3'b001,
    UNVM_ST_WRRD  = 3'b010,
    UNVM_ST_WRPUT = 3'b011,
    UNVM_ST_RDWT  = 3'b100
  } unvm_state_t;
endpackage

/* File: rtl/unvm_mem_if.sv */
// Carrier between the store controller and its byte array.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none

interface unvm_mem_if;
  import unvm_pkg::*;
  logic ra_en;
  unvm_addr_t ra_addr;
  unvm_byte_t ra_data;
  logic rb_en;
  unvm_addr_t rb_addr;
  unvm_byte_t rb_data;
  logic wr_en;
  unvm_addr_t wr_addr;
  unvm_byte_t wr_data;

  modport ctrl (output ra_en, ra_addr, rb_en, rb_addr, wr_en, wr_addr, wr_data,
                input ra_data, rb_data);
  modport mem (input ra_en, ra_addr, rb_en, rb_addr, wr_en, wr_addr, wr_data,
               output ra_data, rb_data);
endinterface

`default_nettype wire

/* File: rtl/unvm_mem.sv */
// Byte array of the user store with two registered read ports and one write.
// Assumes contents survive rst_i, as a nonvolatile array would.
`timescale 1ns/1ps
`default_nettype none

`include "unvm_map.svh"

module unvm_mem #(
  parameter int DEPTH = `UNVM_BANKS * `UNVM_BANK_BYTES
) (
  input wire logic clk_i,
  unvm_mem_if.mem port
);
  import unvm_pkg::*;

  unvm_byte_t mem_ff [DEPTH];

  // Array update and registered reads; no reset on contents
  always_ff @(posedge clk_i) begin
    if (port.wr_en) begin
      mem_ff[port.wr_addr] <= port.wr_data;
    end
    if (port.ra_en) begin
      port.ra_data <= mem_ff[port.ra_addr];
    end
    if (port.rb_en) begin
      port.rb_data <= mem_ff[port.rb_addr];
    end
  end
endmodule

`default_nettype wire

/* File: bench/unvm_checker.sv */
// Port checker for the user byte store top.
// Assumes a bind onto unvm_top, one clock, reset high.
`timescale 1ns/1ps
`default_nettype none
module unvm_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic core_rd_en_i,
  input wire logic core_valid_o,
  input wire logic prog_req_i,
  input wire unvm_pkg::unvm_op_t prog_op_i,
  input wire logic prog_busy_o,
  input wire logic prog_ack_o,
  input wire logic prog_err_o
);
  import unvm_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request taken while idle
  wire take = prog_req_i && !prog_busy_o;
  sequence s_busy8;
    prog_busy_o [*8];
  endsequence
  sequence s_done;
    prog_ack_o && !prog_busy_o;
  endsequence
  property p_valid;
    core_rd_en_i |=> core_valid_o;
  endproperty
  a_valid: assert property (p_valid) else $error("core valid missing");
  property p_novalid;
    !core_rd_en_i |=> !core_valid_o;
  endproperty
  a_novalid: assert property (p_novalid) else $error("core valid without read");
  property p_rd;
    take && prog_op_i == UNVM_OP_READ |=> prog_busy_o ##1 s_done;
  endproperty
  a_rd: assert property (p_rd) else $error("read timing wrong");
  property p_wr;
    take && prog_op_i == UNVM_OP_WRITE |=> prog_busy_o [*2] ##1 s_done;
  endproperty
  a_wr: assert property (p_wr) else $error("write timing wrong");
  property p_er;
    take && prog_op_i == UNVM_OP_ERASE |=> s_busy8 ##1 s_busy8 ##1 s_done;
  endproperty
  a_er: assert property (p_er) else $error("erase timing wrong");
  property p_err_busy;
    prog_req_i && prog_busy_o |=> prog_err_o;
  endproperty
  a_err_busy: assert property (p_err_busy) else $error("busy request not flagged");
  property p_err_none;
    take && prog_op_i == UNVM_OP_NONE |=> prog_err_o && !prog_busy_o;
  endproperty
  a_err_none: assert property (p_err_none) else $error("empty op not flagged");
  property p_ack;
    prog_ack_o |=> !prog_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack longer than one cycle");
  property p_fall;
    $fell(prog_busy_o) |-> prog_ack_o;
  endproperty
  a_fall: assert property (p_fall) else $error("busy fell without ack");
endmodule
bind unvm_top unvm_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .core_rd_en_i(core_rd_en_i), .core_valid_o(core_valid_o), .prog_req_i(prog_req_i),
  .prog_op_i(prog_op_i), .prog_busy_o(prog_busy_o), .prog_ack_o(prog_ack_o),
  .prog_err_o(prog_err_o));
`default_nettype wire

/* File: bench/unvm_core_model.sv */
// Model of the core logic that reads the byte store.
// Assumes the bench calls read() from its own sequence.
`timescale 1ns/1ps
`default_nettype none
module unvm_core_model (
  input wire logic clk_i,
  output logic core_rd_en_o,
  output unvm_pkg::unvm_addr_t core_addr_o,
  input wire unvm_pkg::unvm_byte_t core_data_i,
  input wire logic core_valid_i
);
  import unvm_pkg::*;
  initial begin
    core_rd_en_o = 1'b0;
    core_addr_o = '0;
  end
  // Address held over the taking edge, then released inverted
  task automatic read(input unvm_addr_t a, output unvm_byte_t d, output logic v);
    @(posedge clk_i);
    core_rd_en_o <= 1'b1;
    core_addr_o <= a;
    @(posedge clk_i);
    core_rd_en_o <= 1'b0;
    core_addr_o <= ~a;
    @(negedge clk_i);
    d = core_data_i;
    v = core_valid_i;
  endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the user byte store.
// Assumes the checker is bound and the core model reads.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  import unvm_pkg::*;
  localparam logic [127:0] KEY_T = 128'h3C5A96F01E2D4B78A5C30F69D2E1874B; // Arbitrary
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rd_en;
  unvm_addr_t rd_addr;
  unvm_byte_t rd_data;
  logic rd_vld;
  logic req = 1'b0;
  unvm_op_t op = UNVM_OP_NONE;
  unvm_addr_t addr = '0;
  unvm_byte_t data = '0;
  logic dec = 1'b0;
  logic busy;
  logic ack;
  logic err;
  unvm_byte_t rdata;
  unvm_byte_t exp_mem [128];
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  integer seed = 28;
  unvm_byte_t got;
  logic vld;
  unvm_addr_t a;
  unvm_byte_t d;
  logic dc;
  always #50 clk_i = ~clk_i;
  unvm_top #(.KEY(KEY_T)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .core_rd_en_i(rd_en),
    .core_addr_i(rd_addr), .core_data_o(rd_data), .core_valid_o(rd_vld), .prog_req_i(req),
    .prog_op_i(op), .prog_addr_i(addr), .prog_data_i(data), .prog_decrypt_i(dec),
    .prog_busy_o(busy), .prog_ack_o(ack), .prog_err_o(err), .prog_rdata_o(rdata));
  unvm_core_model u_core (.clk_i(clk_i), .core_rd_en_o(rd_en), .core_addr_o(rd_addr),
    .core_data_i(rd_data), .core_valid_i(rd_vld));
  // Stored byte after a merging load
  function automatic unvm_byte_t f_load(unvm_byte_t o, unvm_byte_t v, logic k, unvm_addr_t p);
    return o & (k ? v ^ KEY_T[p[3:0]*8 +: 8] : v);
  endfunction
  task automatic report_and_stop;
    $display("checks %0d bad %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One programming request, then wait for ack or err
  task automatic prog(input unvm_op_t o, input unvm_addr_t p, input unvm_byte_t v, input logic k);
    int n;
    @(posedge clk_i);
    req <= 1'b1;
    op <= o;
    addr <= p;
    data <= v;
    dec <= k;
    @(posedge clk_i);
    req <= 1'b0;
    data <= ~v;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 30);
  endtask
  task automatic core_chk(input unvm_addr_t p);
    u_core.read(p, got, vld);
    `CHK("core_valid", 1'b1, vld)
    `CHK("core_data", exp_mem[p], got)
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 6000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK("busy", 1'b0, busy)
    `CHK("core_valid", 1'b0, rd_vld)
    $display("test reset done");
    for (int b = 0; b < 8; b++) begin
      prog(UNVM_OP_ERASE, {3'(b), 4'hA}, 8'h00, 1'b0);
      `CHK("erase_ack", 1'b1, ack)
      for (int i = 0; i < 16; i++) begin
        exp_mem[b * 16 + i] = 8'hFF;
        core_chk(7'(b * 16 + i));
      end
    end
    $display("test erase done");
    for (int n = 0; n < 24; n++) begin
      a = (n < 2) ? 7'h7F : 7'($random(seed));
      d = 8'($random(seed));
      dc = 1'($random(seed));
      exp_mem[a] = f_load(exp_mem[a], d, dc, a);
      prog(UNVM_OP_WRITE, a, d, dc);
      `CHK("write_ack", 1'b1, ack)
      prog(UNVM_OP_READ, a, 8'h00, 1'b0);
      `CHK("prog_rdata", exp_mem[a], rdata)
      core_chk(a);
    end
    $display("test write done");
    @(posedge clk_i);
    req <= 1'b1;
    op <= UNVM_OP_ERASE;
    addr <= 7'h05;
    @(posedge clk_i);
    op <= UNVM_OP_READ;
    @(posedge clk_i);
    req <= 1'b0;
    @(negedge clk_i);
    `CHK("busy_err", 1'b1, err)
    repeat (15) @(negedge clk_i);
    `CHK("erase_ack", 1'b1, ack)
    for (int i = 0; i < 16; i++)
      exp_mem[i] = 8'hFF;
    core_chk(7'h03);
    prog(UNVM_OP_NONE, 7'h10, 8'h00, 1'b0);
    `CHK("none_err", 1'b1, err)
    $display("test refuse done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK("reset_busy", 1'b0, busy)
    `CHK("reset_valid", 1'b0, rd_vld)
    core_chk(7'h7F);
    $display("test retain done");
    report_and_stop();
  end
endmodule
`default_nettype wire
